// *** hdl/mdc_pkg.sv ***
package mdc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CORE_PERIOD_PS = 4000;
  localparam int CLK_TYP_PERIOD_PS = 33330;
  localparam int CLK_MAX_PERIOD_PS = 50000;
  // Typical period rounded down stays below the longest period
  localparam int CLK_PERIOD_CYC = CLK_TYP_PERIOD_PS / CORE_PERIOD_PS;
  localparam int CLK_MAX_CYC = CLK_MAX_PERIOD_PS / CORE_PERIOD_PS;
  localparam int CLK_HALF_CYC = CLK_PERIOD_CYC / 2;
  localparam int ERR_TIMEOUT_US = 80;
  localparam int ERR_TIMEOUT_CYC = ERR_TIMEOUT_US * 1000000 / CORE_PERIOD_PS;
  localparam int INIT_CYCLES = 3180;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int APB_AW = 8;
  localparam int SYNC_W = 4 + DATA_W;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LENGTH = 8'h04;
  localparam logic [7:0] REG_EXPECT = 8'h08;
  localparam logic [7:0] REG_BOOT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CHECKSUM = 8'h14;
  localparam logic [7:0] REG_ADDR = 8'h18;

  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_WORD_BIT = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_USER_BIT = 4;
  localparam int STAT_CHAIN_BIT = 5;
  localparam int STAT_ERR_BIT = 8;

  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [31:0] LENGTH_RESET = 32'h0000_0010;
  localparam logic [15:0] EXPECT_RESET = 16'h0000;
  localparam logic [23:0] BOOT_RESET = 24'h01_0000;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_LOAD,
    ST_FORWARD,
    ST_INIT,
    ST_USER,
    ST_ERR_HOLD
  } mdc_state_type;

endpackage

// *** hdl/mdc_clk_if.sv ***
`timescale 1ns/1ps
interface mdc_clk_if;
  logic run;
  logic clkLevel;
  logic periodEnd;
  modport gen (input run, output clkLevel, output periodEnd);
  modport user (output run, input clkLevel, input periodEnd);
endinterface

// *** hdl/mdc_clock_gen.sv ***
`timescale 1ns/1ps
module mdc_clock_gen (
  input wire logic core_clk, // Core clock
  input wire logic nrst, // Asynchronous reset, active low
  mdc_clk_if.gen clkIf // Divided configuration clock
);

  logic [3:0] phase_reg;
  logic [3:0] phase_next;
  logic level_reg;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb
  begin
    if (!clkIf.run || phase_reg == 4'(mdc_pkg::CLK_PERIOD_CYC - 1))
      phase_next = 4'h0;
    else
      phase_next = phase_reg + 4'h1;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      phase_reg <= 4'h0;
    else
      phase_reg <= phase_next;
  end

  // High for the first half period, stands still low while stopped
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      level_reg <= 1'b0;
    else
      level_reg <= clkIf.run && (phase_reg < 4'(mdc_pkg::CLK_HALF_CYC));
  end

  assign clkIf.clkLevel = level_reg;
  // Last core cycle of each period: data launched at the rise has settled
  assign clkIf.periodEnd = clkIf.run && (phase_reg == 4'(mdc_pkg::CLK_PERIOD_CYC - 1));

endmodule

// *** hdl/mdc_config_loader.sv ***
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module mdc_config_loader #(
  parameter int ERR_TIMEOUT_CYC = mdc_pkg::ERR_TIMEOUT_CYC
) (
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic configRequestN, // Configuration request pin
  input wire logic chainEnableInN, // Chain-enable input pin
  output logic chainEnableOutN, // Chain-enable output pin
  input wire logic errorStatusLineNIn, // Shared status line level
  output logic errorStatusLineNOut, // Status drive value, always low
  output logic errorStatusLineNOen, // Status drive enable, low drives
  input wire logic configCompleteIn, // Shared completion line level
  output logic configCompleteOut, // Completion drive value, always low
  output logic configCompleteOen, // Completion drive enable, low drives
  output logic configClockOut, // Configuration clock to flash and slaves
  output logic [23:0] flashAddr, // Flash address
  input wire logic [15:0] flashData, // Flash data bus
  output logic flashCeN, // Flash chip enable
  output logic flashOeN, // Flash output enable
  output logic flashAvdN, // Flash address valid
  output logic flashBusOen, // High floats every flash output
  input wire logic flashReady, // Flash ready, not used
  output logic userMode // Device in user mode
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  mdc_clk_if clkIf ();

  logic [mdc_pkg::SYNC_W-1:0] meta_reg;
  logic [mdc_pkg::SYNC_W-1:0] sync_reg;
  logic reqHigh;
  logic ceInHigh;
  logic statusHigh;
  logic completeHigh;
  logic [15:0] dataSync;

  mdc_pkg::mdc_state_type state_reg;
  mdc_pkg::mdc_state_type state_next;

  logic [1:0] ctrl_reg;
  logic [31:0] length_reg;
  logic [15:0] expect_reg;
  logic [23:0] boot_reg;
  logic errSticky_reg;
  logic [15:0] sum_reg;
  logic [15:0] sum_next;
  logic [15:0] unit;
  logic [31:0] count_reg;
  logic lastUnit;
  logic sumBad;
  logic [15:0] errTimer_reg;
  logic [11:0] initTimer_reg;
  logic [23:0] addr_reg;
  logic busy;
  logic chainOutN_reg;
  logic statusOen_reg;
  logic completeOen_reg;
  logic ceN_reg;
  logic avdN_reg;
  logic busOen_reg;
  logic user_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic pready_reg;
  logic pslverr_reg;
  logic addrHit;
  logic setupPhase;
  logic wrAccess;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= {configCompleteIn, errorStatusLineNIn, configRequestN, chainEnableInN,
        flashData};
      sync_reg <= meta_reg;
    end
  end

  assign completeHigh = sync_reg[mdc_pkg::DATA_W + 3];
  assign statusHigh = sync_reg[mdc_pkg::DATA_W + 2];
  assign reqHigh = sync_reg[mdc_pkg::DATA_W + 1];
  assign ceInHigh = sync_reg[mdc_pkg::DATA_W];
  assign dataSync = sync_reg[mdc_pkg::DATA_W-1:0];

  // ----------------------------------------
  // Configuration clock
  // ----------------------------------------
  assign busy = (state_reg == mdc_pkg::ST_LOAD) || (state_reg == mdc_pkg::ST_FORWARD);
  assign clkIf.run = busy;

  mdc_clock_gen u_clock_gen (
    .core_clk(core_clk),
    .nrst(nrst),
    .clkIf(clkIf.gen)
  );

  // ----------------------------------------
  // Data capture
  // ----------------------------------------
  // Ready from the flash plays no part in the data timing
  always_comb
  begin
    if (ctrl_reg[mdc_pkg::CTRL_WORD_BIT])
      unit = dataSync;
    else
      unit = {8'h00, dataSync[mdc_pkg::BYTE_W-1:0]};
  end

  assign sum_next = sum_reg + unit;
  assign lastUnit = (count_reg == length_reg - 32'h1);
  assign sumBad = (sum_next != expect_reg);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sum_reg <= 16'h0000;
      count_reg <= 32'h0;
    end
    else if (state_reg != mdc_pkg::ST_LOAD)
    begin
      if (state_reg == mdc_pkg::ST_RESET)
      begin
        sum_reg <= 16'h0000;
        count_reg <= 32'h0;
      end
    end
    else if (clkIf.periodEnd)
    begin
      sum_reg <= sum_next;
      count_reg <= count_reg + 32'h1;
    end
  end

  // Keeps stepping after own data so the slaves see the rest
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      addr_reg <= mdc_pkg::BOOT_RESET;
    else if (state_reg == mdc_pkg::ST_RESET)
      addr_reg <= boot_reg;
    else if (busy && clkIf.periodEnd)
      addr_reg <= addr_reg + 24'h1;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      mdc_pkg::ST_RESET:
        if (reqHigh && statusHigh && !ceInHigh)
          state_next = mdc_pkg::ST_LOAD;
      mdc_pkg::ST_LOAD:
        if (clkIf.periodEnd && lastUnit)
          state_next = sumBad ? mdc_pkg::ST_ERR_HOLD : mdc_pkg::ST_FORWARD;
      mdc_pkg::ST_FORWARD:
        // Wait for the period end so the slaves never see a short clock pulse
        if (completeHigh && clkIf.periodEnd)
          state_next = mdc_pkg::ST_INIT;
      mdc_pkg::ST_INIT:
        if (initTimer_reg == 12'(mdc_pkg::INIT_CYCLES - 1))
          state_next = mdc_pkg::ST_USER;
      mdc_pkg::ST_USER:
        state_next = mdc_pkg::ST_USER;
      mdc_pkg::ST_ERR_HOLD:
        if (ctrl_reg[mdc_pkg::CTRL_AUTO_BIT] && errTimer_reg == 16'(ERR_TIMEOUT_CYC - 1))
          state_next = mdc_pkg::ST_RESET;
      default:
        state_next = mdc_pkg::ST_RESET;
    endcase
    if (!reqHigh)
      state_next = mdc_pkg::ST_RESET;
    else if (!statusHigh && state_reg != mdc_pkg::ST_ERR_HOLD)
      state_next = mdc_pkg::ST_RESET;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= mdc_pkg::ST_RESET;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      errTimer_reg <= 16'h0000;
    else if (state_reg == mdc_pkg::ST_ERR_HOLD)
      errTimer_reg <= errTimer_reg + 16'h1;
    else
      errTimer_reg <= 16'h0000;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      initTimer_reg <= 12'h000;
    else if (state_reg == mdc_pkg::ST_INIT)
      initTimer_reg <= initTimer_reg + 12'h1;
    else
      initTimer_reg <= 12'h000;
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      chainOutN_reg <= 1'b1;
      completeOen_reg <= 1'b0;
      statusOen_reg <= 1'b1;
      user_reg <= 1'b0;
    end
    else
    begin
      // Own data taken and chain enabled: pass the chain on
      chainOutN_reg <= !(state_next == mdc_pkg::ST_FORWARD || state_next == mdc_pkg::ST_INIT
        || state_next == mdc_pkg::ST_USER) || ceInHigh;
      completeOen_reg <= (state_next == mdc_pkg::ST_FORWARD || state_next == mdc_pkg::ST_INIT
        || state_next == mdc_pkg::ST_USER);
      statusOen_reg <= (state_next != mdc_pkg::ST_ERR_HOLD);
      user_reg <= (state_next == mdc_pkg::ST_USER);
    end
  end

  // Flash side floats unless this device owns the bus and is loading or forwarding
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busOen_reg <= 1'b1;
      ceN_reg <= 1'b1;
      avdN_reg <= 1'b1;
    end
    else
    begin
      busOen_reg <= !reqHigh || ceInHigh || !(state_next == mdc_pkg::ST_LOAD
        || state_next == mdc_pkg::ST_FORWARD);
      ceN_reg <= !(state_next == mdc_pkg::ST_LOAD || state_next == mdc_pkg::ST_FORWARD);
      avdN_reg <= !(state_next == mdc_pkg::ST_LOAD && state_reg != mdc_pkg::ST_LOAD);
    end
  end

  assign chainEnableOutN = chainOutN_reg;
  assign errorStatusLineNOut = 1'b0;
  assign errorStatusLineNOen = statusOen_reg;
  assign configCompleteOut = 1'b0;
  assign configCompleteOen = completeOen_reg;
  assign configClockOut = clkIf.clkLevel;
  assign flashAddr = addr_reg;
  assign flashCeN = ceN_reg;
  assign flashOeN = ceN_reg;
  assign flashAvdN = avdN_reg;
  assign flashBusOen = busOen_reg;
  assign userMode = user_reg;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign setupPhase = psel && !penable;
  assign wrAccess = psel && penable && pready_reg && pwrite;

  always_comb
  begin
    addrHit = 1'b1;
    rd_next = 32'h0;
    unique case (paddr)
      mdc_pkg::REG_CTRL: rd_next = {30'h0, ctrl_reg};
      mdc_pkg::REG_LENGTH: rd_next = length_reg;
      mdc_pkg::REG_EXPECT: rd_next = {16'h0, expect_reg};
      mdc_pkg::REG_BOOT: rd_next = {8'h00, boot_reg};
      mdc_pkg::REG_STATUS:
      begin
        rd_next[mdc_pkg::STAT_STATE_LSB +: 3] = state_reg;
        rd_next[mdc_pkg::STAT_USER_BIT] = user_reg;
        rd_next[mdc_pkg::STAT_CHAIN_BIT] = !chainOutN_reg;
        rd_next[mdc_pkg::STAT_ERR_BIT] = errSticky_reg;
      end
      mdc_pkg::REG_CHECKSUM: rd_next = {16'h0, sum_reg};
      mdc_pkg::REG_ADDR: rd_next = {8'h00, addr_reg};
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end
    else
    begin
      pready_reg <= setupPhase;
      pslverr_reg <= setupPhase && !addrHit;
      prdata_reg <= (setupPhase && !pwrite) ? rd_next : 32'h0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_reg <= mdc_pkg::CTRL_RESET;
      length_reg <= mdc_pkg::LENGTH_RESET;
      expect_reg <= mdc_pkg::EXPECT_RESET;
      boot_reg <= mdc_pkg::BOOT_RESET;
    end
    else if (wrAccess)
    begin
      if (paddr == mdc_pkg::REG_CTRL)
        ctrl_reg <= pwdata[1:0];
      if (paddr == mdc_pkg::REG_LENGTH)
        length_reg <= pwdata;
      if (paddr == mdc_pkg::REG_EXPECT)
        expect_reg <= pwdata[15:0];
      if (paddr == mdc_pkg::REG_BOOT)
        boot_reg <= pwdata[23:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      errSticky_reg <= 1'b0;
    else if (state_reg == mdc_pkg::ST_LOAD && state_next == mdc_pkg::ST_ERR_HOLD)
      errSticky_reg <= 1'b1;
    else if (wrAccess && paddr == mdc_pkg::REG_STATUS && pwdata[mdc_pkg::STAT_ERR_BIT])
      errSticky_reg <= 1'b0;
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule

// *** bench/mdc_flash_model.sv ***
`timescale 1ns/1ps
module mdc_flash_model (
  input wire logic core_clk, // Core clock
  input wire logic [23:0] flashAddr, // Word address
  input wire logic flashCeN, // Chip enable
  input wire logic flashOeN, // Output enable
  input wire logic flashBusOen, // High means bus floated
  output logic [15:0] flashData // Data bus
);
  logic [15:0] lastData;
  always_ff @(posedge core_clk)
  begin
    lastData <= flashData;
  end
  // Released bus flips every cycle so a stale sample cannot pass
  always_comb
  begin
    if (!flashBusOen && !flashCeN && !flashOeN)
      flashData = flashAddr[15:0] ^ 16'h5A00;
    else
      flashData = ~lastData;
  end
endmodule

// *** bench/mdc_config_loader_asserts.sv ***
`timescale 1ns/1ps
module mdc_config_loader_asserts #(
  parameter int ERR_TIMEOUT_CYC = mdc_pkg::ERR_TIMEOUT_CYC
) (
  input wire logic core_clk, // Core clock
  input wire logic nrst, // Reset, active low
  input wire logic configRequestN, // Request pin
  input wire logic chainEnableInN, // Chain-enable in
  input wire logic chainEnableOutN, // Chain-enable out
  input wire logic errorStatusLineNOen, // Status drive enable
  input wire logic configCompleteIn, // Completion line
  input wire logic configCompleteOen, // Completion drive enable
  input wire logic configClockOut, // Configuration clock
  input wire logic flashBusOen, // Flash bus float
  input wire logic userMode // User mode
);
  int initCnt;
  int errCnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      initCnt <= 0;
    else if (configCompleteIn && configCompleteOen && configRequestN)
      initCnt <= initCnt + 1;
    else
      initCnt <= 0;
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      errCnt <= 0;
    else if (!errorStatusLineNOen)
      errCnt <= errCnt + 1;
    else
      errCnt <= 0;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_pair;
    configCompleteOen == !chainEnableOutN;
  endproperty
  a_pair: assert property (p_pair) else $error("completion and chain out disagree");
  property p_rst;
    !configRequestN [*5] |-> chainEnableOutN && !configCompleteOen && !userMode;
  endproperty
  a_rst: assert property (p_rst) else $error("not held in reset");
  property p_float;
    !configRequestN [*5] |-> flashBusOen;
  endproperty
  a_float: assert property (p_float) else $error("flash bus driven in reset");
  property p_owner;
    chainEnableInN [*5] |-> flashBusOen && chainEnableOutN;
  endproperty
  a_owner: assert property (p_owner) else $error("bus taken while not owner");
  property p_err;
    !errorStatusLineNOen |-> chainEnableOutN && !configCompleteOen;
  endproperty
  a_err: assert property (p_err) else $error("chain passed during error");
  // Request low may cut a clock phase short
  property p_clk;
    @(posedge core_clk) disable iff (!nrst || !configRequestN)
    $rose(configClockOut) && errorStatusLineNOen
      |-> configClockOut [*4] ##1 !configClockOut [*4];
  endproperty
  a_clk: assert property (p_clk) else $error("clock period wrong");
  property p_init;
    $rose(userMode) |-> initCnt >= mdc_pkg::INIT_CYCLES && initCnt <= mdc_pkg::INIT_CYCLES + 10;
  endproperty
  a_init: assert property (p_init) else $error("init count wrong");
  property p_auto;
    $rose(errorStatusLineNOen) && configRequestN
      |-> errCnt >= ERR_TIMEOUT_CYC - 1 && errCnt <= ERR_TIMEOUT_CYC + 2;
  endproperty
  a_auto: assert property (p_auto) else $error("restart time wrong");
endmodule
bind mdc_config_loader mdc_config_loader_asserts #(.ERR_TIMEOUT_CYC(ERR_TIMEOUT_CYC)) chk_inst (
  .core_clk, .nrst, .configRequestN, .chainEnableInN, .chainEnableOutN,
  .errorStatusLineNOen, .configCompleteIn, .configCompleteOen, .configClockOut,
  .flashBusOen, .userMode
);

// *** bench/mdc_config_loader_tb_top.sv ***
`timescale 1ns/1ps
module mdc_config_loader_tb_top;
  localparam int TMO = 20;
  localparam int LEN = 6;
  localparam logic [23:0] BOOT = 24'h000120;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic configRequestN, chainEnableInN, chainEnableOutN, slaveDoneN;
  logic errorStatusLineNIn, errorStatusLineNOut, errorStatusLineNOen;
  logic configCompleteIn, configCompleteOut, configCompleteOen, configClockOut;
  logic [23:0] flashAddr;
  logic [15:0] flashData;
  logic flashCeN, flashOeN, flashAvdN, flashBusOen, flashReady, userMode;
  int err_count, comparisons, n;
  // Pull-ups on shared lines; a slave may hold completion low
  assign errorStatusLineNIn = errorStatusLineNOen | errorStatusLineNOut;
  assign configCompleteIn = (configCompleteOen | configCompleteOut) & slaveDoneN;
  mdc_config_loader #(.ERR_TIMEOUT_CYC(TMO)) mdc_config_loader_inst (
    .core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .configRequestN, .chainEnableInN, .chainEnableOutN, .errorStatusLineNIn,
    .errorStatusLineNOut, .errorStatusLineNOen, .configCompleteIn, .configCompleteOut,
    .configCompleteOen, .configClockOut, .flashAddr, .flashData, .flashCeN, .flashOeN,
    .flashAvdN, .flashBusOen, .flashReady, .userMode
  );
  mdc_flash_model mdc_flash_model_inst (
    .core_clk, .flashAddr, .flashCeN, .flashOeN, .flashBusOen, .flashData
  );
  initial
  begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) flashReady <= ~flashReady;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = chainEnableOutN;
      1: pick = errorStatusLineNOen;
      2: pick = userMode;
      default: pick = flashBusOen;
    endcase
  endfunction
  task automatic waitfor(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(n < lim, 1);
  endtask
  function automatic logic [15:0] csum(input logic w);
    logic [15:0] s, d;
    s = 16'h0000;
    for (int i = 0; i < LEN; i++)
    begin
      d = 16'(BOOT + 24'(i)) ^ 16'h5A00;
      s = s + (w ? d : {8'h00, d[7:0]});
    end
    return s;
  endfunction
  task automatic cfg(input logic [1:0] c, input logic [15:0] e);
    apb(1, mdc_pkg::REG_CTRL, {30'h0, c});
    apb(1, mdc_pkg::REG_LENGTH, LEN);
    apb(1, mdc_pkg::REG_EXPECT, {16'h0000, e});
    apb(1, mdc_pkg::REG_BOOT, {8'h00, BOOT});
  endtask
  // Low for 130 cycles of 4 ns, just beyond 125
  task automatic pulse;
    configRequestN <= 1'b0;
    repeat (130) @(posedge core_clk);
    configRequestN <= 1'b1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    apb(0, mdc_pkg::REG_CTRL, 0);
    chk(rd, 32'h00000001);
    apb(0, mdc_pkg::REG_LENGTH, 0);
    chk(rd, 32'h00000010);
    apb(0, mdc_pkg::REG_EXPECT, 0);
    chk(rd, 32'h00000000);
    apb(0, mdc_pkg::REG_BOOT, 0);
    chk(rd, 32'h00010000);
    apb(0, 8'h40, 0);
    chk(rd, 32'h0);
    chk(se, 1);
    $display("test regs done");
  endtask
  task automatic t_good(input logic w);
    cfg({w, 1'b1}, csum(w));
    pulse();
    waitfor(0, 1'b0, 400);
    chk(n >= LEN * 8, 1);
    chk(configCompleteOen, 1);
    apb(0, mdc_pkg::REG_CHECKSUM, 0);
    chk(rd[15:0], csum(w));
    repeat (200) @(posedge core_clk);
    chk(userMode, 0);
    slaveDoneN <= 1'b1;
    waitfor(2, 1'b1, 4000);
    chk(n >= mdc_pkg::INIT_CYCLES, 1);
    slaveDoneN <= 1'b0;
    $display("test load width %0d done", w);
  endtask
  task automatic t_error(input logic auto);
    cfg({1'b0, auto}, 16'hFFFF);
    pulse();
    waitfor(1, 1'b0, 400);
    chk(chainEnableOutN, 1);
    apb(0, mdc_pkg::REG_STATUS, 0);
    chk(rd[8], 1);
    if (!auto)
    begin
      repeat (100) @(posedge core_clk);
      chk(errorStatusLineNOen, 0);
      configRequestN <= 1'b0;
    end
    waitfor(1, 1'b1, 40);
    chk(errorStatusLineNOen, 1);
    configRequestN <= 1'b0;
    repeat (5) @(posedge core_clk);
    apb(1, mdc_pkg::REG_STATUS, 32'h00000100);
    apb(0, mdc_pkg::REG_STATUS, 0);
    chk(rd[8], 0);
    $display("test error auto %0d done", auto);
  endtask
  task automatic t_takeover;
    configRequestN <= 1'b0;
    chainEnableInN <= 1'b1;
    repeat (130) @(posedge core_clk);
    chk(flashBusOen, 1);
    configRequestN <= 1'b1;
    repeat (40) @(posedge core_clk);
    chk(flashBusOen, 1);
    chk(chainEnableOutN, 1);
    apb(0, mdc_pkg::REG_ADDR, 0);
    chk(rd, {8'h00, BOOT});
    chk(flashAddr, BOOT);
    apb(0, mdc_pkg::REG_STATUS, 0);
    chk(rd, 32'h0);
    chainEnableInN <= 1'b0;
    pulse();
    waitfor(3, 1'b0, 20);
    chk(flashBusOen, 0);
    chk({flashAvdN, flashCeN, flashOeN}, 0);
    @(posedge core_clk);
    chk(flashAvdN, 1);
    $display("test takeover done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    final_report();
  end
  initial
  begin
    nrst = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    configRequestN = 1;
    chainEnableInN = 0;
    slaveDoneN = 0;
    flashReady = 0;
    err_count = 0;
    comparisons = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_good(1'b0);
    t_good(1'b1);
    t_error(1'b1);
    t_error(1'b0);
    t_takeover();
    final_report();
  end
endmodule
